// file: design/lpts_pkg.sv
// Shared constants and types of the line pulse template shaper.
package lpts_pkg;

    // ==========================================================================
    // Register indexes and APB address width
    // ==========================================================================
    localparam logic [7:0] RX_IF_CFG_IDX   = 8'h03;
    localparam logic [7:0] TX_IF_CFG_IDX   = 8'h04;
    localparam logic [7:0] MASTER_DIAG_IDX = 8'h0A;
    localparam logic [7:0] LINE_LEN_IDX    = 8'h14;
    localparam logic [7:0] IND_ADDR_IDX    = 8'h16;
    localparam logic [7:0] IND_DATA_IDX    = 8'h17;
    localparam int         APB_AW          = 8;

    // ==========================================================================
    // Field positions and reset values
    // ==========================================================================
    localparam int         RX_UNI_BIT      = 0;
    localparam int         TX_UNI_BIT      = 0;
    localparam int         METAL_LB_BIT    = 3;
    localparam int         ILS_LSB         = 0;
    localparam int         SM_BIT          = 6;
    localparam int         RPT_BIT         = 7;
    localparam logic [7:0] RX_IF_CFG_RST   = 8'h00;
    localparam logic [7:0] TX_IF_CFG_RST   = 8'h00;
    localparam logic [7:0] MASTER_DIAG_RST = 8'h00;
    localparam logic [7:0] LINE_LEN_RST    = 8'h40;
    localparam logic [7:0] IND_ADDR_RST    = 8'h00;
    localparam logic [3:0] CODE_RST        = 4'h0;

    // ==========================================================================
    // Pulse timing and slicer
    // ==========================================================================
    localparam int         NUM_CODES       = 8;
    localparam int         BODY_CODES      = 4;
    localparam logic [3:0] HS_DIV          = 4'h1;
    localparam logic [3:0] MON_THRESHOLD   = 4'h6;

    typedef enum logic {LPTS_IDLE, LPTS_RUN} lpts_state_t;

    // Built-in templates, index 0 in the top nibble, one entry per length band, bands 6 and 7 sharing the last.
    function automatic logic [31:0] lpts_rom(input logic [2:0] band);
        case (band)
            3'h0:    lpts_rom = 32'hBAAA3321;
            3'h1:    lpts_rom = 32'hCBAA4321;
            3'h2:    lpts_rom = 32'hECBB5421;
            3'h3:    lpts_rom = 32'hEDBB6531;
            3'h4:    lpts_rom = 32'hFEBB8531;
            3'h5:    lpts_rom = 32'hFCBA8531;
            default: lpts_rom = 32'hFCAAA531;
        endcase
    endfunction : lpts_rom

endpackage : lpts_pkg

// file: design/lpts_sync3.sv
// Three-stage pin synchroniser with agreement filter on the last two stages.
module lpts_sync3 #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] agree;
    logic [W-1:0] dout_next;

    // A bit changes only when the second and third stages agree.
    assign agree     = ~(s2_reg ^ s3_reg);
    assign dout_next = (agree & s3_reg) | (~agree & dout);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            dout   <= '0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            dout   <= dout_next;
        end
    end
endmodule : lpts_sync3

// file: design/lpts_template_store.sv
// Eight 4-bit custom template code registers with indexed write and reads.
module lpts_template_store
    import lpts_pkg::*;
(
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Software port
    input  wire logic         wr_en,
    input  wire logic [2:0]   wr_idx,
    input  wire logic [3:0]   wr_code,
    input  wire logic [2:0]   rd_idx,
    output logic      [3:0]   rd_code,
    // Sequencer port
    input  wire logic [2:0]   seq_idx,
    output logic      [3:0]   seq_code
);
    logic [3:0] code_mem [NUM_CODES];

    assign rd_code  = code_mem[rd_idx];
    assign seq_code = code_mem[seq_idx];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CODES; i++) begin
                code_mem[i] <= CODE_RST;
            end
        end else if (wr_en) begin
            code_mem[wr_idx] <= wr_code;
        end
    end
endmodule : lpts_template_store

// file: design/lpts_shaper.sv
// Transmit pulse template shaper with APB registers and metallic loopback.
module lpts_shaper
    import lpts_pkg::*;
(
    // APB clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Transmit pulse pins
    input  wire logic        smoothed_tx_clock,
    input  wire logic        tx_pulse_pos,
    input  wire logic        tx_pulse_neg,
    // Line receive rails from the receive slicer
    input  wire logic        line_rx_pos,
    input  wire logic        line_rx_neg,
    // D/A codes and amplifier controls
    output logic      [3:0]  line_out_pos_code,
    output logic      [3:0]  line_out_neg_code,
    output logic             line_out_pos_ground,
    output logic             line_out_neg_ground,
    // Clock and data recovery rail inputs
    output logic             cdr_in_pos,
    output logic             cdr_in_neg,
    // Configuration levels for the neighbouring blocks
    output logic             rx_unipolar_select,
    output logic             tx_unipolar_select
);
    // ==========================================================================
    // Address decode
    // ==========================================================================
    function automatic logic [APB_AW-1:0] byte_addr(input logic [7:0] idx);
        byte_addr = {idx[5:0], 2'b00};
    endfunction : byte_addr

    logic [7:0] rx_if_cfg_reg;
    logic [7:0] tx_if_cfg_reg;
    logic [7:0] master_diag_reg;
    logic [7:0] line_len_reg;
    logic [7:0] ind_addr_reg;

    // Any upper address bit set makes the access unmapped, so aliases answer with an error.
    wire  [APB_AW-1:0] addr_lo  = paddr[APB_AW-1:0];
    wire               addr_hi0 = (paddr[31:APB_AW] == '0);
    wire               sel_rx   = addr_hi0 && (addr_lo == byte_addr(RX_IF_CFG_IDX));
    wire               sel_tx   = addr_hi0 && (addr_lo == byte_addr(TX_IF_CFG_IDX));
    wire               sel_diag = addr_hi0 && (addr_lo == byte_addr(MASTER_DIAG_IDX));
    wire               sel_len  = addr_hi0 && (addr_lo == byte_addr(LINE_LEN_IDX));
    wire               sel_iadr = addr_hi0 && (addr_lo == byte_addr(IND_ADDR_IDX));
    wire               sel_idat = addr_hi0 && (addr_lo == byte_addr(IND_DATA_IDX));
    wire               mapped   = sel_rx | sel_tx | sel_diag | sel_len | sel_iadr | sel_idat;

    // The answer costs one wait state so that read data leaves a flip-flop.
    wire               access   = psel && penable && !pready;
    wire               commit   = psel && penable && pready;
    wire               wr_ok    = commit && pwrite && mapped && pstrb[0];

    // ==========================================================================
    // Template store and indirect access
    // ==========================================================================
    logic [3:0] custom_rd_code;
    logic [3:0] custom_seq_code;
    logic [2:0] step_reg;

    // Reads of the data register show the custom store even while a built-in template runs.
    lpts_template_store u_store (
        .pclk     (pclk),
        .presetn  (presetn),
        .wr_en    (wr_ok && sel_idat),
        .wr_idx   (ind_addr_reg[2:0]),
        .wr_code  (pwdata[3:0]),
        .rd_idx   (ind_addr_reg[2:0]),
        .rd_code  (custom_rd_code),
        .seq_idx  (step_reg),
        .seq_code (custom_seq_code)
    );

    // ==========================================================================
    // Register read mux
    // ==========================================================================
    logic [7:0] rd_mux;

    assign rd_mux = sel_rx   ? rx_if_cfg_reg   :
                    sel_tx   ? tx_if_cfg_reg   :
                    sel_diag ? master_diag_reg :
                    sel_len  ? line_len_reg    :
                    sel_iadr ? ind_addr_reg    :
                    sel_idat ? {4'h0, custom_rd_code} :
                    8'h00;

    logic [31:0] prdata_next;
    logic        pready_next;
    logic        pslverr_next;

    assign pready_next  = access;
    assign pslverr_next = access && !mapped;
    assign prdata_next  = (access && !pwrite) ? {24'h000000, rd_mux} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h00000000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata  <= prdata_next;
            pready  <= pready_next;
            pslverr <= pslverr_next;
        end
    end

    // ==========================================================================
    // Configuration registers
    // ==========================================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_if_cfg_reg   <= RX_IF_CFG_RST;
            tx_if_cfg_reg   <= TX_IF_CFG_RST;
            master_diag_reg <= MASTER_DIAG_RST;
            line_len_reg    <= LINE_LEN_RST;
            ind_addr_reg    <= IND_ADDR_RST;
        end else if (wr_ok) begin
            if (sel_rx) begin
                rx_if_cfg_reg <= pwdata[7:0];
            end
            if (sel_tx) begin
                tx_if_cfg_reg <= pwdata[7:0];
            end
            if (sel_diag) begin
                master_diag_reg <= pwdata[7:0];
            end
            if (sel_len) begin
                line_len_reg <= pwdata[7:0];
            end
            if (sel_iadr) begin
                ind_addr_reg <= pwdata[7:0];
            end
        end
    end

    wire        custom_template_enable = line_len_reg[RPT_BIT];
    wire        template_select_enable = line_len_reg[SM_BIT];
    wire [2:0]  line_length_select     = line_len_reg[ILS_LSB +: 3];
    wire        metallic_loopback      = master_diag_reg[METAL_LB_BIT];

    // Software is expected to keep these consistent during loopback; the block
    // only publishes them and does not police them.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_unipolar_select <= 1'b0;
            tx_unipolar_select <= 1'b0;
        end else begin
            rx_unipolar_select <= rx_if_cfg_reg[RX_UNI_BIT];
            tx_unipolar_select <= tx_if_cfg_reg[TX_UNI_BIT];
        end
    end

    // ==========================================================================
    // Pin synchronisers
    // ==========================================================================
    // The synchroniser resets low while the transmit clock idles high, so
    // release shows a rise and never a false fall.
    logic [2:0] pins_sync;

    lpts_sync3 #(
        .W (3)
    ) u_pin_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     ({smoothed_tx_clock, tx_pulse_pos, tx_pulse_neg}),
        .dout    (pins_sync)
    );

    wire tclk_s = pins_sync[2];
    wire pos_s  = pins_sync[1];
    wire neg_s  = pins_sync[0];

    // ==========================================================================
    // High-speed sub-clock and transmit clock edge
    // ==========================================================================
    logic [3:0] hs_cnt_reg;
    logic       tclk_d_reg;
    logic       arm_reg;

    wire        hs_tick   = (hs_cnt_reg == HS_DIV - 4'h1);
    wire        tclk_fall = tclk_d_reg && !tclk_s;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hs_cnt_reg <= 4'h0;
            tclk_d_reg <= 1'b0;
        end else begin
            hs_cnt_reg <= hs_tick ? 4'h0 : hs_cnt_reg + 4'h1;
            tclk_d_reg <= tclk_s;
        end
    end

    // ==========================================================================
    // Template source selection
    // ==========================================================================
    logic [31:0] rom_word;
    logic [3:0]  rom_code;
    logic [3:0]  seq_code;

    // Without template select the shortest-line template is the fallback.
    assign rom_word = lpts_rom(template_select_enable ? line_length_select : 3'h0);
    assign rom_code = rom_word[(3'h7 - step_reg) * 4 +: 4];
    assign seq_code = custom_template_enable ? custom_seq_code : rom_code;

    // ==========================================================================
    // Pulse sequencer
    // ==========================================================================
    lpts_state_t state_reg;
    lpts_state_t state_next;
    logic        polarity_reg;
    logic        has_pulse_reg;
    logic [2:0]  step_next;
    logic        polarity_next;
    logic        has_pulse_next;
    logic        arm_next;

    // The falling transmit clock arms the sequencer; the next sub-clock tick
    // applies code 0, so a fall and a tick in one cycle start at once.
    always_comb begin
        state_next     = state_reg;
        step_next      = step_reg;
        polarity_next  = polarity_reg;
        has_pulse_next = has_pulse_reg;
        arm_next       = arm_reg || tclk_fall;
        case (state_reg)
            LPTS_IDLE: begin
                if (arm_next && hs_tick) begin
                    state_next     = LPTS_RUN;
                    step_next      = 3'h0;
                    polarity_next  = neg_s && !pos_s;
                    has_pulse_next = pos_s || neg_s;
                    arm_next       = 1'b0;
                end
            end
            LPTS_RUN: begin
                if (hs_tick) begin
                    if (step_reg == 3'(NUM_CODES - 1)) begin
                        state_next     = LPTS_IDLE;
                        has_pulse_next = 1'b0;
                        step_next      = 3'h0;
                    end else begin
                        step_next = step_reg + 3'h1;
                    end
                end
            end
            default: begin
                state_next = LPTS_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg     <= LPTS_IDLE;
            step_reg      <= 3'h0;
            polarity_reg  <= 1'b0;
            has_pulse_reg <= 1'b0;
            arm_reg       <= 1'b0;
        end else begin
            state_reg     <= state_next;
            step_reg      <= step_next;
            polarity_reg  <= polarity_next;
            has_pulse_reg <= has_pulse_next;
            arm_reg       <= arm_next;
        end
    end

    // ==========================================================================
    // Output steering
    // ==========================================================================
    wire in_body   = (step_reg < 3'(BODY_CODES));
    wire active    = (state_reg == LPTS_RUN) && has_pulse_reg;
    // Body goes to the pulse's own rail, tail to the opposite rail.
    wire drive_pos = active && (in_body ^ polarity_reg);
    wire drive_neg = active && !(in_body ^ polarity_reg);

    logic [3:0] pos_code_next;
    logic [3:0] neg_code_next;

    assign pos_code_next = drive_pos ? seq_code : 4'h0;
    assign neg_code_next = drive_neg ? seq_code : 4'h0;

    // ==========================================================================
    // Monitor slicers and loopback
    // ==========================================================================
    // The slicers watch the registered codes, which are what the amplifiers
    // drive, so the recovery rails trail the line by one cycle. Long-line
    // templates can cross the threshold on the tail.
    wire mon_pos = (line_out_pos_code >= MON_THRESHOLD);
    wire mon_neg = (line_out_neg_code >= MON_THRESHOLD);

    wire cdr_pos_next = metallic_loopback ? mon_pos : line_rx_pos;
    wire cdr_neg_next = metallic_loopback ? mon_neg : line_rx_neg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_out_pos_code   <= 4'h0;
            line_out_neg_code   <= 4'h0;
            line_out_pos_ground <= 1'b1;
            line_out_neg_ground <= 1'b1;
            cdr_in_pos          <= 1'b0;
            cdr_in_neg          <= 1'b0;
        end else begin
            line_out_pos_code   <= pos_code_next;
            line_out_neg_code   <= neg_code_next;
            line_out_pos_ground <= !drive_pos;
            line_out_neg_ground <= !drive_neg;
            cdr_in_pos          <= cdr_pos_next;
            cdr_in_neg          <= cdr_neg_next;
        end
    end

endmodule : lpts_shaper

// file: tb/lpts_line_model.sv
// Behavioural line transformer and amplifier pair feeding the receive slicer rails.
module lpts_line_model #(
    parameter logic [3:0] RX_LEVEL = 4'h4
) (
    // Amplifier drive
    input  wire logic [3:0] line_out_pos_code,
    input  wire logic [3:0] line_out_neg_code,
    input  wire logic       line_out_pos_ground,
    input  wire logic       line_out_neg_ground,
    // Sliced line rails
    output logic            line_rx_pos,
    output logic            line_rx_neg
);
    timeunit 1ns;
    timeprecision 1ps;
    // A grounded amplifier gives no swing, so only the driving side can trip a rail.
    assign line_rx_pos = !line_out_pos_ground && (line_out_pos_code > RX_LEVEL);
    assign line_rx_neg = !line_out_neg_ground && (line_out_neg_code > RX_LEVEL);
endmodule : lpts_line_model

// file: tb/lpts_shaper_properties.sv
// Port-level checker of the line pulse template shaper and its bind.
module lpts_shaper_checker
    import lpts_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pulse and line
    input wire logic        smoothed_tx_clock,
    input wire logic        tx_pulse_pos,
    input wire logic        line_rx_pos,
    input wire logic        line_rx_neg,
    input wire logic [3:0]  line_out_pos_code,
    input wire logic [3:0]  line_out_neg_code,
    input wire logic        line_out_pos_ground,
    input wire logic        line_out_neg_ground,
    input wire logic        cdr_in_pos,
    input wire logic        cdr_in_neg
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================================
    // Loopback mirror
    // ==========================================================================
    // The loopback state is mirrored from committed writes, since it is not visible at the ports.
    logic lb_reg;
    wire logic mapped = paddr inside {32'h0C, 32'h10, 32'h28, 32'h50, 32'h58, 32'h5C};
    wire logic wr_diag = psel && penable && pready && pwrite && pstrb[0] && paddr == 32'h28;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) lb_reg <= 1'b0;
        else if (wr_diag) lb_reg <= pwdata[3];
    end

    // ==========================================================================
    // Properties
    // ==========================================================================
    property p_ready; psel && penable && !pready |=> pready; endproperty
    property p_err; pready |-> pslverr == !mapped; endproperty
    property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
    property p_pgnd; line_out_pos_ground |-> line_out_pos_code == 4'h0; endproperty
    property p_ngnd; line_out_neg_ground |-> line_out_neg_code == 4'h0; endproperty
    property p_rail; line_out_pos_ground || line_out_neg_ground; endproperty
    property p_body;
        $fell(line_out_pos_ground) && $past(line_out_neg_ground) && line_out_neg_ground |->
            (!line_out_pos_ground && line_out_neg_ground)[*4] ##1 (line_out_pos_ground && !line_out_neg_ground)[*4];
    endproperty
    property p_start; $fell(smoothed_tx_clock) && tx_pulse_pos |-> ##[2:12] !line_out_pos_ground; endproperty
    property p_cdr;
        1'b1 |=> {cdr_in_pos, cdr_in_neg} == ($past(lb_reg) ?
            {$past(line_out_pos_code) >= MON_THRESHOLD, $past(line_out_neg_code) >= MON_THRESHOLD} :
            {$past(line_rx_pos), $past(line_rx_neg)});
    endproperty

    a_ready: assert property (p_ready) else $error("pready not raised after one wait state");
    a_err: assert property (p_err) else $error("pslverr wrong for the address");
    a_hi: assert property (p_hi) else $error("prdata upper bits not zero");
    a_pgnd: assert property (p_pgnd) else $error("grounded positive rail carries a code");
    a_ngnd: assert property (p_ngnd) else $error("grounded negative rail carries a code");
    a_rail: assert property (p_rail) else $error("both rails driving at once");
    a_body: assert property (p_body) else $error("body and tail steps out of shape");
    a_start: assert property (p_start) else $error("pulse did not start after clock fall");
    a_cdr: assert property (p_cdr) else $error("recovery rails do not follow source");

    c_code: cover property (psel && penable && pready && pwrite && paddr == 32'h5C);
    c_pos: cover property (!line_out_pos_ground);
    c_loop: cover property (lb_reg && cdr_in_pos);
endmodule : lpts_shaper_checker

bind lpts_shaper lpts_shaper_checker chk_u (.*);

// file: tb/tb.sv
// Self-checking testbench of the line pulse template shaper.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, lb;
    logic [31:0] paddr, pwdata, prdata, rd_v;
    logic [3:0]  pstrb, line_out_pos_code, line_out_neg_code;
    logic        smoothed_tx_clock, tx_pulse_pos, tx_pulse_neg, line_rx_pos, line_rx_neg;
    logic        line_out_pos_ground, line_out_neg_ground, cdr_in_pos, cdr_in_neg;
    logic        rx_unipolar_select, tx_unipolar_select;
    int          mismatches = 0, checks = 0, seed = 20139;
    logic [31:0] rom [7] = '{32'hBAAA3321, 32'hCBAA4321, 32'hECBB5421, 32'hEDBB6531,
                             32'hFEBB8531, 32'hFCBA8531, 32'hFCAAA531};
    logic [31:0] ra [5] = '{32'h0C, 32'h10, 32'h28, 32'h50, 32'h58};
    logic [31:0] rv [5] = '{32'h00, 32'h00, 32'h00, 32'h40, 32'h00};
    logic [3:0]  cs [8];

    lpts_shaper dut_u (.*);
    lpts_line_model line_u (.*);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ==========================================================================
    // Tasks
    // ==========================================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk(n < 20, 32'h1);
        rd_v = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic e = 1'b0);
        apb(1'b1, a, d, 4'hF);
        chk(err, e);
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] x, input logic e = 1'b0);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(rd_v, x);
        chk(err, e);
    endtask : rd

    function automatic logic [31:0] want(input logic [7:0] cfg);
        if (cfg[7]) return {cs[0], cs[1], cs[2], cs[3], cs[4], cs[5], cs[6], cs[7]};
        if (cfg[6]) return rom[cfg[2:0] > 3'h6 ? 3'h6 : cfg[2:0]];
        return rom[0];
    endfunction : want

    // One transmit clock cycle carrying a pulse, with every step of both rails compared.
    task automatic pulse(input logic pos, input logic [31:0] w);
        int n;
        logic [3:0] c, pc, nc;
        n = 0;
        pc = 4'h0;
        nc = 4'h0;
        tx_pulse_pos <= pos;
        tx_pulse_neg <= !pos;
        smoothed_tx_clock <= 1'b1;
        repeat (4) @(posedge pclk);
        smoothed_tx_clock <= 1'b0;
        do begin
            @(negedge pclk);
            n++;
        end while (line_out_pos_ground && line_out_neg_ground && n < 20);
        for (int s = 0; s < 8; s++) begin
            c = w[31 - 4 * s -: 4];
            if ((s < 4) == pos) chk({line_out_pos_ground, line_out_neg_ground, line_out_pos_code, line_out_neg_code},
                                    {2'b01, c, 4'h0});
            else chk({line_out_pos_ground, line_out_neg_ground, line_out_pos_code, line_out_neg_code},
                     {2'b10, 4'h0, c});
            if (lb) chk({cdr_in_pos, cdr_in_neg}, {pc >= 4'h6, nc >= 4'h6});
            pc = line_out_pos_code;
            nc = line_out_neg_code;
            @(negedge pclk);
        end
        @(posedge pclk);
        tx_pulse_pos <= 1'b0;
        tx_pulse_neg <= 1'b0;
        smoothed_tx_clock <= 1'b1;
        repeat (8) @(posedge pclk);
    endtask : pulse

    task automatic results;
        if (mismatches == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // ==========================================================================
    // Sequence
    // ==========================================================================
    initial begin
        #100000;
        $display("ERROR %0t watchdog expired", $time);
        mismatches++;
        results();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, lb} = '0;
        {smoothed_tx_clock, tx_pulse_pos, tx_pulse_neg} = 3'b100;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ra[i]) rd(ra[i], rv[i]);
        rd(32'h5C, 32'h0);
        rd(32'h60, 32'h0, 1'b1);
        wr(32'h60, 32'hFF, 1'b1);
        wr(32'h0C, 32'h01);
        wr(32'h10, 32'h01);
        @(negedge pclk);
        chk({rx_unipolar_select, tx_unipolar_select}, 32'h3);
        @(posedge pclk);
        rd(32'h10, 32'h01);
        wr(32'h0C, 32'h00);
        wr(32'h10, 32'h00);
        for (int i = 0; i < 8; i++) begin
            wr(32'h50, {24'h0, 5'b01000, i[2:0]});
            pulse(i[0], want({5'b01000, i[2:0]}));
        end
        wr(32'h50, 32'h03);
        pulse(1'b1, want(8'h03));
        wr(32'h50, 32'h00);
        for (int i = 0; i < 8; i++) begin
            cs[i] = 4'({$random(seed)} % 15 + 1);
            wr(32'h58, {29'h0, i[2:0]});
            wr(32'h5C, {28'h0, cs[i]});
        end
        wr(32'h58, 32'h03);
        apb(1'b1, 32'h5C, 32'h0, 4'h0);
        for (int i = 7; i >= 0; i--) begin
            wr(32'h58, {29'h0, i[2:0]});
            rd(32'h5C, {28'h0, cs[i]});
        end
        wr(32'h50, 32'h80);
        pulse(1'b1, want(8'h80));
        pulse(1'b0, want(8'h80));
        wr(32'h50, 32'h40);
        wr(32'h28, 32'h08);
        lb = 1'b1;
        pulse(1'b1, rom[0]);
        pulse(1'b0, rom[0]);
        rd(32'h28, 32'h08);
        wr(32'h28, 32'h00);
        lb = 1'b0;
        results();
    end
endmodule : tb
